// file: spi_port_device.sv
// serial peripheral port, master or slave, registers on ahb-lite
`timescale 1ns/1ps
module spi_port_device (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // interrupt
   input wire logic irqAck,
   output logic irq,
   // link
   spi_link.device link
);
   logic [7:0] ctrlReg;
   logic [3:0] pinsReg;
   logic doubleRate, flag, write_collision_flag, armFlag, armWcol;
   logic wrPend;
   logic [3:0] wrAddr;
   logic [7:0] shreg, rxBuf;
   logic outBit, sckPrev;
   logic [3:0] bitCnt;
   logic sckOeN, mosiOeN, misoOeN, ssOeN;
   logic genSck, genLead, genTrail, genBusy, genFinish;
   logic accept, rdStat, dataAcc, dataWrite, ctrlWrite;
   logic en, isMaster, lsb, cpol, cpha;
   logic modeFault, xferBusy, load, collide, genRun;
   logic sSel, sEdge, sLead, sample, setup, xferDone, inBit;

   assign en = ctrlReg[spi_port_pkg::CTRL_ENABLE];
   assign isMaster = ctrlReg[spi_port_pkg::CTRL_MASTER];
   assign lsb = ctrlReg[spi_port_pkg::CTRL_LSB_FIRST];
   assign cpol = ctrlReg[spi_port_pkg::CTRL_CPOL];
   assign cpha = ctrlReg[spi_port_pkg::CTRL_CPHA];

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign accept = hsel && htrans[1] && hready;
   assign rdStat = accept && !hwrite && haddr[3:0] == spi_port_pkg::OFS_STAT;
   assign dataAcc = accept && haddr[3:0] == spi_port_pkg::OFS_DATA;
   assign dataWrite = wrPend && wrAddr == spi_port_pkg::OFS_DATA;
   assign ctrlWrite = wrPend && wrAddr == spi_port_pkg::OFS_CTRL;

   // ----------------------------------------
   // transfer control
   // ----------------------------------------
   // own select drive must be off before a low select counts as a fault
   assign modeFault = en && isMaster && !pinsReg[spi_port_pkg::PINS_SS_OUT_DIR]
                      && ssOeN && !link.ssN;
   assign xferBusy = isMaster ? genBusy : (bitCnt != 4'h0);
   assign load = en && dataWrite && !xferBusy;
   assign collide = en && dataWrite && xferBusy;
   assign genRun = load && isMaster;
   assign sSel = en && !isMaster && !link.ssN;
   assign sEdge = sSel && (link.sck != sckPrev);
   assign sLead = link.sck != cpol;
   assign inBit = isMaster ? link.miso : link.mosi;
   assign sample = isMaster ? (cpha ? genTrail : genLead)
                            : (sEdge && (cpha ^ sLead));
   assign setup = isMaster ? (cpha ? genLead : genTrail)
                           : (sEdge && !(cpha ^ sLead));
   assign xferDone = (isMaster && genFinish)
                     || (!isMaster && sample && bitCnt == spi_port_pkg::LAST_BIT);

   spi_sck_gen gen (
      .ref_clk(ref_clk), .rst_n(rst_n), .run(genRun),
      .halfDiv(spi_port_pkg::halfPeriod(ctrlReg[1:0], doubleRate)),
      .cpol(cpol), .sck(genSck), .leadEdge(genLead), .trailEdge(genTrail),
      .busy(genBusy), .finish(genFinish)
   );

   // ----------------------------------------
   // bus slave: zero wait, read data from address phase
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         wrPend <= 1'b0;
         wrAddr <= 4'h0;
      end else begin
         wrPend <= accept && hwrite && hsize == 3'h2;
         wrAddr <= haddr[3:0];
         if (accept && !hwrite) begin
            unique case (haddr[3:0])
               spi_port_pkg::OFS_CTRL: hrdata <= {24'h000000, ctrlReg};
               spi_port_pkg::OFS_STAT: hrdata <= {24'h000000, flag, write_collision_flag, 5'h00, doubleRate};
               spi_port_pkg::OFS_DATA: hrdata <= {24'h000000, rxBuf};
               spi_port_pkg::OFS_PINS: hrdata <= {28'h0000000, pinsReg};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlReg <= spi_port_pkg::CTRL_RESET;
         pinsReg <= spi_port_pkg::PINS_RESET;
         doubleRate <= 1'b0;
      end else begin
         if (ctrlWrite) begin
            ctrlReg <= hwdata[7:0];
         end
         if (modeFault) begin
            ctrlReg[spi_port_pkg::CTRL_MASTER] <= 1'b0;
         end
         if (wrPend && wrAddr == spi_port_pkg::OFS_STAT) begin
            doubleRate <= hwdata[spi_port_pkg::STAT_DOUBLE];
         end
         if (wrPend && wrAddr == spi_port_pkg::OFS_PINS) begin
            pinsReg <= hwdata[3:0];
         end
      end
   end

   // ----------------------------------------
   // status flags, set wins over clear
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b0;
         write_collision_flag <= 1'b0;
         armFlag <= 1'b0;
         armWcol <= 1'b0;
         irq <= 1'b0;
      end else begin
         if (rdStat) begin
            armFlag <= flag;
            armWcol <= write_collision_flag;
         end else if (dataAcc) begin
            armFlag <= 1'b0;
            armWcol <= 1'b0;
         end
         if (xferDone || modeFault) begin
            flag <= 1'b1;
         end else if (irqAck || (armFlag && dataAcc)) begin
            flag <= 1'b0;
         end
         if (collide) begin
            write_collision_flag <= 1'b1;
         end else if (armWcol && dataAcc) begin
            write_collision_flag <= 1'b0;
         end
         irq <= flag && ctrlReg[spi_port_pkg::CTRL_IRQ_EN] && !irqAck;
      end
   end

   // ----------------------------------------
   // shift path
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         shreg <= 8'h00;
         outBit <= 1'b0;
         bitCnt <= 4'h0;
         sckPrev <= 1'b1;
         rxBuf <= 8'h00;
      end else begin
         sckPrev <= link.sck;
         if (load) begin
            shreg <= hwdata[7:0];
            outBit <= spi_port_pkg::headBit(hwdata[7:0], lsb);
         end else if (sample) begin
            shreg <= spi_port_pkg::shiftIn(shreg, inBit, lsb);
            if (!isMaster) begin
               bitCnt <= (bitCnt == spi_port_pkg::LAST_BIT) ? 4'h0 : 4'(bitCnt + 4'h1);
            end
         end else if (setup) begin
            outBit <= spi_port_pkg::headBit(shreg, lsb);
         end else if (!isMaster && link.ssN) begin
            bitCnt <= 4'h0;
            outBit <= spi_port_pkg::headBit(shreg, lsb);
         end
         if (!isMaster && sample && bitCnt == spi_port_pkg::LAST_BIT) begin
            rxBuf <= spi_port_pkg::shiftIn(shreg, inBit, lsb);
         end else if (isMaster && genFinish) begin
            // with cpha set the last sample lands on the finishing edge
            rxBuf <= sample ? spi_port_pkg::shiftIn(shreg, inBit, lsb) : shreg;
         end
      end
   end

   // ----------------------------------------
   // pin direction overrides
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sckOeN <= 1'b1;
         mosiOeN <= 1'b1;
         misoOeN <= 1'b1;
         ssOeN <= 1'b1;
      end else begin
         sckOeN <= !(en && isMaster && pinsReg[spi_port_pkg::PINS_MOSI_SCK_DRV]);
         mosiOeN <= !(en && isMaster && pinsReg[spi_port_pkg::PINS_MOSI_SCK_DRV]);
         misoOeN <= !(sSel && pinsReg[spi_port_pkg::PINS_MISO_DRV]);
         ssOeN <= !(en && isMaster && pinsReg[spi_port_pkg::PINS_SS_OUT_DIR]);
      end
   end

   assign link.devSckO = genSck;
   assign link.devSckOeN = sckOeN;
   assign link.devMosiO = outBit;
   assign link.devMosiOeN = mosiOeN;
   assign link.devMisoO = outBit;
   assign link.devMisoOeN = misoOeN;
   assign link.devSsO = pinsReg[spi_port_pkg::PINS_SS_LEVEL];
   assign link.devSsOeN = ssOeN;
endmodule : spi_port_device

// file: spi_port_pkg.sv
// shared constants, types and helpers for the serial peripheral port
package spi_port_pkg;

   // ----------------------------------------
   // register offsets (haddr[3:0])
   // ----------------------------------------
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STAT = 4'h4;
   localparam logic [3:0] OFS_DATA = 4'h8;
   localparam logic [3:0] OFS_PINS = 4'hc;

   // ----------------------------------------
   // serial_control_register fields
   // ----------------------------------------
   localparam int CTRL_IRQ_EN = 7;
   localparam int CTRL_ENABLE = 6;
   localparam int CTRL_LSB_FIRST = 5;
   localparam int CTRL_MASTER = 4;
   localparam int CTRL_CPOL = 3;
   localparam int CTRL_CPHA = 2;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ----------------------------------------
   // status fields
   // ----------------------------------------
   localparam int STAT_FLAG = 7;
   localparam int STAT_WRITE_COLLISION_FLAG = 6;
   localparam int STAT_DOUBLE = 0;

   // ----------------------------------------
   // pin direction register fields
   // ----------------------------------------
   localparam int PINS_SS_OUT_DIR = 0;
   localparam int PINS_SS_LEVEL = 1;
   localparam int PINS_MOSI_SCK_DRV = 2;
   localparam int PINS_MISO_DRV = 3;
   localparam logic [3:0] PINS_RESET = 4'h2;

   // ----------------------------------------
   // byte framing
   // ----------------------------------------
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam logic [6:0] PEER_HALF_DIV = 7'h02;

   typedef enum logic [2:0] {
      PEER_IDLE = 3'b001,
      PEER_SELECT = 3'b010,
      PEER_SHIFT = 3'b100
   } peer_state_e;

   // half sck period in clocks: divisors 4/16/64/128, halved when doubled
   function automatic logic [6:0] halfPeriod(input logic [1:0] rate, input logic dbl);
      logic [6:0] h;
      h = 7'h02;
      unique case (rate)
         2'h0: h = 7'h02;
         2'h1: h = 7'h08;
         2'h2: h = 7'h20;
         2'h3: h = 7'h40;
      endcase
      if (dbl) begin
         h = (rate == 2'h3) ? 7'h20 : {1'b0, h[6:1]};
      end
      return h;
   endfunction : halfPeriod

   // shift one received bit into the byte
   function automatic logic [7:0] shiftIn(input logic [7:0] b, input logic d,
                                          input logic lsb);
      return lsb ? {d, b[7:1]} : {b[6:0], d};
   endfunction : shiftIn

   // bit presented on the line next
   function automatic logic headBit(input logic [7:0] b, input logic lsb);
      return lsb ? b[0] : b[7];
   endfunction : headBit

endpackage : spi_port_pkg

// file: spi_link.sv
// serial link between the port and its peer, with pin resolution
`timescale 1ns/1ps
interface spi_link;
   // port drive, enables low while driving
   logic devSckO, devSckOeN, devMosiO, devMosiOeN;
   logic devMisoO, devMisoOeN, devSsO, devSsOeN;
   // peer drive
   logic peerSckO, peerSckOeN, peerMosiO, peerMosiOeN;
   logic peerMisoO, peerMisoOeN, peerSsO, peerSsOeN;
   // resolved line levels, undriven lines pulled high
   logic sck, mosi, miso, ssN;

   assign sck = !devSckOeN ? devSckO : (!peerSckOeN ? peerSckO : 1'b1);
   assign mosi = !devMosiOeN ? devMosiO : (!peerMosiOeN ? peerMosiO : 1'b1);
   assign miso = !devMisoOeN ? devMisoO : (!peerMisoOeN ? peerMisoO : 1'b1);
   assign ssN = !devSsOeN ? devSsO : (!peerSsOeN ? peerSsO : 1'b1);

   modport device (
      output devSckO, devSckOeN, devMosiO, devMosiOeN,
      output devMisoO, devMisoOeN, devSsO, devSsOeN,
      input sck, mosi, miso, ssN
   );
   modport peer (
      output peerSckO, peerSckOeN, peerMosiO, peerMosiOeN,
      output peerMisoO, peerMisoOeN, peerSsO, peerSsOeN,
      input sck, mosi, miso, ssN
   );
endinterface : spi_link

// file: spi_sck_gen.sv
// sck generator: sixteen edges per byte, then stops
`timescale 1ns/1ps
module spi_sck_gen (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // control
   input wire logic run,
   input wire logic [6:0] halfDiv,
   input wire logic cpol,
   // clock and edge strobes
   output logic sck,
   output logic leadEdge,
   output logic trailEdge,
   output logic busy,
   output logic finish
);
   logic [6:0] divCnt;
   logic [3:0] edgeCnt;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck <= 1'b0;
         leadEdge <= 1'b0;
         trailEdge <= 1'b0;
         busy <= 1'b0;
         finish <= 1'b0;
         divCnt <= 7'h00;
         edgeCnt <= 4'h0;
      end else begin
         leadEdge <= 1'b0;
         trailEdge <= 1'b0;
         finish <= 1'b0;
         if (!busy) begin
            sck <= cpol;
            if (run) begin
               busy <= 1'b1;
               divCnt <= 7'(halfDiv - 7'h01);
               edgeCnt <= 4'h0;
            end
         end else if (divCnt != 7'h00) begin
            divCnt <= 7'(divCnt - 7'h01);
         end else begin
            sck <= ~sck;
            divCnt <= 7'(halfDiv - 7'h01);
            leadEdge <= ~edgeCnt[0];
            trailEdge <= edgeCnt[0];
            edgeCnt <= 4'(edgeCnt + 4'h1);
            if (edgeCnt == spi_port_pkg::LAST_EDGE) begin
               busy <= 1'b0;
               finish <= 1'b1;
            end
         end
      end
   end
endmodule : spi_sck_gen

// file: spi_peer_end.sv
// external peer: master or slave on the far side of the link
`timescale 1ns/1ps
module spi_peer_end (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // link
   spi_link.peer link,
   // configuration
   input wire logic roleMaster,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic lsbFirst,
   input wire logic holdSelect,
   // byte exchange
   input wire logic start,
   input wire logic [7:0] txByte,
   output logic busy,
   output logic done,
   output logic [7:0] rxByte
);
   spi_port_pkg::peer_state_e state;
   logic [7:0] shreg;
   logic outBit, sckPrev, ssReg, genRun, oeM, oeS;
   logic [3:0] bitCnt;
   logic genSck, genLead, genTrail, genBusy, genFinish;
   logic sSel, sEdge, sLead, sample, setup;

   spi_sck_gen gen (
      .ref_clk(ref_clk), .rst_n(rst_n), .run(genRun),
      .halfDiv(spi_port_pkg::PEER_HALF_DIV), .cpol(cpol), .sck(genSck),
      .leadEdge(genLead), .trailEdge(genTrail), .busy(genBusy), .finish(genFinish)
   );

   assign sSel = !roleMaster && !link.ssN;
   assign sEdge = sSel && (link.sck != sckPrev);
   assign sLead = link.sck != cpol;
   assign sample = roleMaster ? (cpha ? genTrail : genLead) : (sEdge && (cpha ^ sLead));
   assign setup = roleMaster ? (cpha ? genLead : genTrail) : (sEdge && !(cpha ^ sLead));

   // ----------------------------------------
   // master sequencing
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= spi_port_pkg::PEER_IDLE;
         ssReg <= 1'b1;
         genRun <= 1'b0;
      end else begin
         genRun <= 1'b0;
         unique case (state)
            spi_port_pkg::PEER_IDLE: begin
               if (roleMaster && start) begin
                  ssReg <= 1'b0;
                  state <= spi_port_pkg::PEER_SELECT;
               end else if (!holdSelect) begin
                  ssReg <= 1'b1;
               end
            end
            spi_port_pkg::PEER_SELECT: begin
               genRun <= 1'b1;
               state <= spi_port_pkg::PEER_SHIFT;
            end
            spi_port_pkg::PEER_SHIFT: begin
               if (genFinish) begin
                  ssReg <= holdSelect;
                  state <= spi_port_pkg::PEER_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // shifting, both roles
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         shreg <= 8'h00;
         outBit <= 1'b0;
         bitCnt <= 4'h0;
         sckPrev <= 1'b1;
         rxByte <= 8'h00;
         done <= 1'b0;
         busy <= 1'b0;
      end else begin
         sckPrev <= link.sck;
         done <= 1'b0;
         busy <= roleMaster ? (state != spi_port_pkg::PEER_IDLE) : (bitCnt != 4'h0);
         if (start && state == spi_port_pkg::PEER_IDLE && bitCnt == 4'h0) begin
            shreg <= txByte;
            outBit <= spi_port_pkg::headBit(txByte, lsbFirst);
         end else if (sample) begin
            shreg <= spi_port_pkg::shiftIn(shreg, roleMaster ? link.miso : link.mosi,
                                           lsbFirst);
            bitCnt <= (bitCnt == spi_port_pkg::LAST_BIT) ? 4'h0 : 4'(bitCnt + 4'h1);
            if (!roleMaster && bitCnt == spi_port_pkg::LAST_BIT) begin
               rxByte <= spi_port_pkg::shiftIn(shreg, link.mosi, lsbFirst);
               done <= 1'b1;
            end
         end else if (setup) begin
            outBit <= spi_port_pkg::headBit(shreg, lsbFirst);
         end else if (!roleMaster && link.ssN) begin
            bitCnt <= 4'h0;
         end
         if (roleMaster && genFinish) begin
            // with cpha set the last sample lands on the finishing edge
            rxByte <= sample ? spi_port_pkg::shiftIn(shreg, link.miso, lsbFirst) : shreg;
            done <= 1'b1;
            bitCnt <= 4'h0;
         end
      end
   end

   // ----------------------------------------
   // pin enables
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         oeM <= 1'b1;
         oeS <= 1'b1;
      end else begin
         oeM <= !roleMaster;
         oeS <= !(sSel);
      end
   end

   assign link.peerSckO = genSck;
   assign link.peerSckOeN = oeM;
   assign link.peerMosiO = outBit;
   assign link.peerMosiOeN = oeM;
   assign link.peerSsO = ssReg;
   assign link.peerSsOeN = oeM;
   assign link.peerMisoO = outBit;
   assign link.peerMisoOeN = oeS;
endmodule : spi_peer_end

// file: spi_port_asserts.sv
// link checker for the serial port facing its peer end
`timescale 1ns/1ps
module spi_port_asserts (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // driver enables, low while driving
   input wire logic devSckOeN,
   input wire logic devMosiOeN,
   input wire logic devMisoOeN,
   input wire logic devSsOeN,
   input wire logic peerSckOeN,
   // resolved lines
   input wire logic sck,
   input wire logic ssN
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // ---
   // peer clock edges
   // ---
   sequence peerEdge;
      !peerSckOeN && !$past(peerSckOeN) && $changed(sck);
   endsequence
   sequence sckHeld;
      peerSckOeN || $stable(sck);
   endsequence

   // ---
   // checks
   // ---
   chk_peer_sck_rate: assert property (peerEdge |=> sckHeld)
      else $error("peer clock edges too close");
   chk_select_first: assert property (peerEdge |-> !ssN)
      else $error("clock edge without select");
   chk_one_clock: assert property (!(!devSckOeN && !peerSckOeN))
      else $error("two clock drivers");
   property slaveInputs;
      !devMisoOeN |-> devSckOeN && devMosiOeN && devSsOeN;
   endproperty
   chk_slave_pins: assert property (slaveInputs)
      else $error("slave drives an input pin");
   chk_master_miso_in: assert property (!devSckOeN |-> devMisoOeN)
      else $error("master drives miso");
   chk_master_pin_pair: assert property (!devMosiOeN |-> !devSckOeN)
      else $error("mosi driven without clock");
   chk_ss_master_only: assert property (!devSsOeN |-> devMisoOeN)
      else $error("select driven as slave");
   chk_miso_selected: assert property (!devMisoOeN |-> !$past(ssN))
      else $error("miso driven while deselected");
   chk_miso_release: assert property ($rose(ssN) |=> devMisoOeN)
      else $error("miso kept after deselect");
endmodule : spi_port_asserts

// file: tb_spi_port_device.sv
// self-checking bench: serial port against a peer end
`timescale 1ns/1ps
module tb_spi_port_device;
   logic ref_clk = 1'h0, rst_n = 1'h0, hwrite = 1'h0, irqAck = 1'h0, rdTake = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, irq, peerBusy, peerDone, d;
   logic roleMaster = 1'h0, cpol = 1'h0, cpha = 1'h0, lsb = 1'h0, hold = 1'h0, start = 1'h0;
   logic [7:0] peerRx, peerTx = 8'h0, pd, b;
   logic [2:0] m;
   int n_errors = 0, tests_run = 0, seed = 84;
   logic [31:0] rq[$];
   logic [7:0] pq[$];

   spi_link link();
   spi_port_device spi_port_device_i(.ref_clk, .rst_n, .hsel(1'h1), .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irqAck, .irq,
      .link(link.device));
   spi_peer_end spi_peer_end_i(.ref_clk, .rst_n, .link(link.peer), .roleMaster, .cpol, .cpha,
      .lsbFirst(lsb), .holdSelect(hold), .start, .txByte(peerTx), .busy(peerBusy),
      .done(peerDone), .rxByte(peerRx));
   spi_port_asserts spi_port_asserts_i(.ref_clk, .rst_n, .devSckOeN(link.devSckOeN),
      .devMosiOeN(link.devMosiOeN), .devMisoOeN(link.devMisoOeN), .devSsOeN(link.devSsOeN),
      .peerSckOeN(link.peerSckOeN), .sck(link.sck), .ssN(link.ssN));

   initial forever #5 ref_clk = ~ref_clk;

   // ---
   // tasks
   // ---
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic summarize;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v, input logic ck);
      @(posedge ref_clk);
      htrans <= 2'h2;
      haddr <= {28'h0, a};
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= v;
      rdTake <= !w && ck;
      do @(posedge ref_clk); while (hreadyout !== 1'h1);
      rdTake <= 1'h0;
   endtask : bus

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      rq.push_back(e);
      bus(1'h0, a, 32'h0, 1'h1);
   endtask : rd

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      bus(1'h1, a, v, 1'h0);
   endtask : wr

   task automatic cfg(input logic [7:0] c, input logic [3:0] p, input logic dbl);
      wr(spi_port_pkg::OFS_PINS, {28'h0, p});
      wr(spi_port_pkg::OFS_CTRL, {24'h0, c});
      wr(spi_port_pkg::OFS_STAT, {31'h0, dbl});
   endtask : cfg

   task automatic waitFlag;
      do bus(1'h0, spi_port_pkg::OFS_STAT, 32'h0, 1'h0);
      while (hrdata[spi_port_pkg::STAT_FLAG] !== 1'h1);
   endtask : waitFlag

   task automatic kick(input logic [7:0] t);
      while (peerBusy !== 1'h0) @(posedge ref_clk);
      peerTx <= t;
      start <= 1'h1;
      @(posedge ref_clk);
      start <= 1'h0;
   endtask : kick

   // ---
   // result monitor
   // ---
   always @(posedge ref_clk) begin
      if (rdTake && rq.size() > 0) begin
         check("hrdata", hrdata, rq.pop_front());
         check("hresp", {31'h0, hresp}, 32'h0);
      end
      if (peerDone === 1'h1 && pq.size() > 0) begin
         check("peer rx", {24'h0, peerRx}, {24'h0, pq.pop_front()});
      end
   end

   initial begin
      #500000;
      n_errors++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'h1;
      rd(spi_port_pkg::OFS_CTRL, 32'h0);
      rd(spi_port_pkg::OFS_PINS, 32'h2);
      rd(spi_port_pkg::OFS_DATA, 32'h0);
      wr(spi_port_pkg::OFS_STAT, 32'hc1);
      rd(spi_port_pkg::OFS_STAT, 32'h1);
      // device master, every mode, order and rate
      for (int i = 0; i < 8; i++) begin
         m = 3'(i);
         d = m[2] & m[0];
         b = 8'($random(seed));
         pd = 8'($random(seed));
         {lsb, cpha, cpol} <= m;
         cfg({2'h1, m[2], 1'h1, m[0], m[1], m[1:0]}, 4'h7, d);
         kick(pd);
         wr(spi_port_pkg::OFS_PINS, 32'h5);
         pq.push_back(b);
         wr(spi_port_pkg::OFS_DATA, {24'h0, b});
         if (i == 0) wr(spi_port_pkg::OFS_DATA, {24'h0, ~b});
         waitFlag();
         rd(spi_port_pkg::OFS_STAT, {24'h0, 1'h1, i == 0, 5'h0, d});
         rd(spi_port_pkg::OFS_DATA, {24'h0, pd});
         rd(spi_port_pkg::OFS_STAT, {31'h0, d});
      end
      // device slave, peer master
      {lsb, cpha, cpol} <= 3'h0;
      // port lets go of clock and select before the peer takes them
      cfg(8'hc0, 4'h8, 1'h0);
      roleMaster <= 1'h1;
      b = 8'($random(seed));
      wr(spi_port_pkg::OFS_DATA, {24'h0, b});
      pq.push_back(b);
      kick(8'($random(seed)));
      waitFlag();
      check("irq", {31'h0, irq}, 32'h1);
      irqAck <= 1'h1;
      @(posedge ref_clk);
      irqAck <= 1'h0;
      repeat (2) @(posedge ref_clk);
      check("irq", {31'h0, irq}, 32'h0);
      rd(spi_port_pkg::OFS_STAT, 32'h0);
      b = 8'($random(seed));
      pd = 8'($random(seed));
      pq.push_back(b);
      wr(spi_port_pkg::OFS_DATA, {24'h0, b});
      kick(pd);
      waitFlag();
      rd(spi_port_pkg::OFS_DATA, {24'h0, pd});
      // master with select as input, pulled low by peer
      cfg(8'h50, 4'h0, 1'h0);
      kick(8'($random(seed)));
      waitFlag();
      rd(spi_port_pkg::OFS_CTRL, 32'h40);
      repeat (40) @(posedge ref_clk);
      summarize();
   end
endmodule : tb_spi_port_device
